// File: logic/gpio_edge_pkg.sv
// Constants, register map and bus carrier types for the edge interrupt and logic-function expander block
package gpio_edge_pkg;

  localparam int unsigned NUM_IO = 16;
  localparam int unsigned BANK_IO = 8;
  localparam int unsigned NUM_TABLES = 6;

  // Register byte addresses, one aligned word each
  localparam logic [7:0] ADDR_IO_VALUE = 8'h00;
  localparam logic [7:0] ADDR_IO_DIRECTION = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] ADDR_EDGE_SENSE_LOW = 8'h0c;
  localparam logic [7:0] ADDR_EDGE_SENSE_HIGH = 8'h10;
  localparam logic [7:0] ADDR_IRQ_SOURCE = 8'h14;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h18;
  localparam logic [7:0] ADDR_LOGIC_MODE_BANK_A = 8'h1c;
  localparam logic [7:0] ADDR_LOGIC_MODE_BANK_B = 8'h20;
  localparam logic [7:0] ADDR_TABLE_BASE = 8'h24;
  localparam logic [7:0] ADDR_ADVANCED_OPTIONS = 8'h3c;

  // Values after reset
  localparam logic [15:0] IO_VALUE_RST = 16'hffff;
  localparam logic [15:0] IO_DIRECTION_RST = 16'hffff;
  localparam logic [15:0] IRQ_MASK_RST = 16'hffff;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Advanced options fields
  localparam int unsigned ADV_AUTOCLEAR_BIT = 0;

  // Reset value of the three-bit priming register; edges are believed once its top bit fills
  localparam logic [2:0] PRIME_RST = 3'h0;

  typedef enum logic [1:0] {
    SENSE_NONE = 2'b00,
    SENSE_RISING = 2'b01,
    SENSE_FALLING = 2'b10,
    SENSE_BOTH = 2'b11
  } edge_sense_t;

  // Lower pair of a bank's logic mode; the upper pair shares 01 and 10
  localparam logic [1:0] MODE_GPIO = 2'b00;
  localparam logic [1:0] MODE_2IN = 2'b01;
  localparam logic [1:0] MODE_3IN = 2'b10;
  localparam logic [1:0] MODE_3TO2 = 2'b11;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

endpackage

// File: logic/logic_bank.sv
// Programmable logic function for one bank of eight I/Os
`timescale 1ns/1ps
module logic_bank (
  input wire logic [7:0] mode,
  input wire logic [7:0] table_lo,
  input wire logic [7:0] table_pair,
  input wire logic [7:0] table_hi,
  input wire logic [7:0] pins,
  output logic [7:0] used,
  output logic [7:0] drive,
  output logic [7:0] value
);

  always_comb
  begin
    used = 8'h00;
    drive = 8'h00;
    value = 8'h00;
    unique case (mode[1:0])
      gpio_edge_pkg::MODE_GPIO:
      begin
        used = 8'h00;
      end
      gpio_edge_pkg::MODE_2IN:
      begin
        used[2:0] = 3'h7;
        drive[2] = 1'b1;
        value[2] = table_lo[{pins[1], pins[0]}];
      end
      gpio_edge_pkg::MODE_3IN:
      begin
        used[3:0] = 4'hf;
        drive[3] = 1'b1;
        value[3] = table_lo[pins[2:0]];
      end
      gpio_edge_pkg::MODE_3TO2:
      begin
        used[4:0] = 5'h1f;
        drive[4:3] = 2'h3;
        value[3] = table_lo[pins[2:0]];
        value[4] = table_pair[pins[2:0]];
      end
    endcase
    // Three-to-two takes I/O 4 from the upper nibble, so the upper field is ignored
    if (mode[1:0] != gpio_edge_pkg::MODE_3TO2)
    begin
      case (mode[5:4])
        gpio_edge_pkg::MODE_2IN:
        begin
          used[6:4] = 3'h7;
          drive[6] = 1'b1;
          value[6] = table_hi[{pins[5], pins[4]}];
        end
        gpio_edge_pkg::MODE_3IN:
        begin
          used[7:4] = 4'hf;
          drive[7] = 1'b1;
          value[7] = table_hi[pins[6:4]];
        end
        default:
        begin
          used[7:4] = 4'h0;
        end
      endcase
    end
  end

endmodule

// File: logic/gpio_edge_irq.sv
// Sixteen-I/O expander core: edge interrupts, logic functions and AXI4-Lite registers
//
// Summary of operation
// - Reset clears edge logic and leaves the interrupt pin released.
// - Interrupt mask resets to all ones, blocking every I/O.
// - Reset clears every transition flag; no change is reported.
// - Enabled I/O with a selected rising, falling or both edge raises the interrupt.
// - Interrupt source register shows which I/Os caused the pending interrupt.
// - Interrupt pin held low while pending, released once cleared.
// - Writing ones to interrupt source clears it, matching event bits, releases pin.
// - Advanced option lets a read of the I/O value register clear interrupts.
// - Two-bit edge sense: 00 none, 01 rising, 10 falling, 11 both.
// - Mask bit zero lets an I/O interrupt; one blocks it.
// - I/Os outside logic modes stay GPIO; logic I/Os get direction automatically.
// - Direction bits ignored on logic I/Os; inputs still readable and interrupting.
// - Lower mode 00 all GPIO, 01 two-in at I/O 2, 10 three-in at I/O 3.
// - Lower mode 11 is three-to-two on I/O 0-4; upper field then ignored.
// - Upper mode 01 two-in at I/O 6, 10 three-in at I/O 7, 00 GPIO.
// - Each eight-I/O bank has its own logic mode register.
// - Two-input output is truth table bit indexed by {I/O1, I/O0}.
// - Four three-to-one or two three-to-two fully programmable functions.
`timescale 1ns/1ps
module gpio_edge_irq (
  input wire logic clock,
  input wire logic nrst,
  input wire gpio_edge_pkg::axi_req_t axi_req,
  output gpio_edge_pkg::axi_rsp_t axi_rsp,
  input wire logic [15:0] io_in,
  output logic [15:0] io_out,
  output logic [15:0] io_oe_n,
  output logic irq_out_low,
  output logic irq_out_low_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [15:0] io_value_r;
  logic [15:0] io_direction_r;
  logic [15:0] irq_mask_r;
  logic [31:0] edge_sense_r;
  logic [15:0] irq_source_r;
  logic [15:0] irq_source_nxt;
  logic [15:0] event_status_r;
  logic [15:0] event_status_nxt;
  logic [7:0] logic_mode_bank_a_r;
  logic [7:0] logic_mode_bank_b_r;
  logic [7:0] truth_table_r [gpio_edge_pkg::NUM_TABLES];
  logic [7:0] advanced_options_reg_r;

  logic [15:0] sync1_r;
  logic [15:0] sync2_r;
  logic [15:0] prev_r;
  logic [2:0] prime_r;
  logic [15:0] edge_hit;

  logic [15:0] used;
  logic [15:0] drive;
  logic [15:0] value;
  logic [15:0] io_out_r;
  logic [15:0] io_oe_n_r;
  logic irq_oe_n_r;

  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  logic wr_fire;
  logic rd_fire;
  logic [15:0] wr_val_16;
  logic [7:0] wr_val_8;
  logic wr_hit;
  logic [15:0] rd_val;
  logic rd_hit;
  logic [15:0] clear_bits;
  logic [15:0] source_clear;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[15:8] = data[15:8];
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser and edge detection

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
      prev_r <= 16'h0000;
      prime_r <= gpio_edge_pkg::PRIME_RST;
    end
    else
    begin
      sync1_r <= io_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      // Pipeline must fill before an edge is trusted, else reset looks like a change
      prime_r <= {prime_r[1:0], 1'b1};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_edge
      logic rise;
      logic fall;
      assign rise = sync2_r[gi] & ~prev_r[gi];
      assign fall = ~sync2_r[gi] & prev_r[gi];
      always_comb
      begin
        edge_hit[gi] = 1'b0;
        if (prime_r[2])
        begin
          unique case (gpio_edge_pkg::edge_sense_t'(edge_sense_r[2*gi +: 2]))
            gpio_edge_pkg::SENSE_NONE: edge_hit[gi] = 1'b0;
            gpio_edge_pkg::SENSE_RISING: edge_hit[gi] = rise;
            gpio_edge_pkg::SENSE_FALLING: edge_hit[gi] = fall;
            gpio_edge_pkg::SENSE_BOTH: edge_hit[gi] = rise | fall;
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Logic function banks

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_bank
      logic_bank u_bank (
        .mode((gi == 0) ? logic_mode_bank_a_r : logic_mode_bank_b_r),
        .table_lo(truth_table_r[3*gi]),
        .table_pair(truth_table_r[3*gi + 1]),
        .table_hi(truth_table_r[3*gi + 2]),
        .pins(sync2_r[8*gi +: 8]),
        .used(used[8*gi +: 8]),
        .drive(drive[8*gi +: 8]),
        .value(value[8*gi +: 8])
      );
    end
  endgenerate

  // Logic I/Os take their direction from the mode, the rest from the direction register
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      io_out_r <= gpio_edge_pkg::IO_VALUE_RST;
      io_oe_n_r <= 16'hffff;
    end
    else
    begin
      io_oe_n_r <= (used & ~drive) | (~used & io_direction_r);
      io_out_r <= (drive & value) | (~drive & io_value_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags and pin

  // Autoclear clears everything on a read of the I/O value register
  assign source_clear = (rd_fire && axi_req.araddr == gpio_edge_pkg::ADDR_IO_VALUE &&
                         advanced_options_reg_r[gpio_edge_pkg::ADV_AUTOCLEAR_BIT]) ? 16'hffff : 16'h0000;
  assign clear_bits = (wr_fire && aw_addr_r == gpio_edge_pkg::ADDR_IRQ_SOURCE) ? wr_val_16 : 16'h0000;

  // A new edge in the clearing cycle survives the clear
  assign irq_source_nxt = (irq_source_r & ~(clear_bits | source_clear)) | (edge_hit & ~irq_mask_r);
  assign event_status_nxt = (event_status_r & ~(clear_bits | source_clear |
                             ((wr_fire && aw_addr_r == gpio_edge_pkg::ADDR_EVENT_STATUS) ? wr_val_16 : 16'h0000)))
                            | edge_hit;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      irq_source_r <= gpio_edge_pkg::FLAGS_RST;
      event_status_r <= gpio_edge_pkg::FLAGS_RST;
      irq_oe_n_r <= 1'b1;
    end
    else
    begin
      irq_source_r <= irq_source_nxt;
      event_status_r <= event_status_nxt;
      irq_oe_n_r <= ~(|irq_source_nxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  assign wr_fire = ~awready_r & ~wready_r & ~bvalid_r;
  assign wr_val_16 = merge16(16'h0000, w_data_r, w_strb_r);
  assign wr_val_8 = w_strb_r[0] ? w_data_r[7:0] : 8'h00;

  always_comb
  begin
    wr_hit = 1'b1;
    unique case (aw_addr_r)
      gpio_edge_pkg::ADDR_IO_VALUE, gpio_edge_pkg::ADDR_IO_DIRECTION, gpio_edge_pkg::ADDR_IRQ_MASK,
      gpio_edge_pkg::ADDR_EDGE_SENSE_LOW, gpio_edge_pkg::ADDR_EDGE_SENSE_HIGH, gpio_edge_pkg::ADDR_IRQ_SOURCE,
      gpio_edge_pkg::ADDR_EVENT_STATUS, gpio_edge_pkg::ADDR_LOGIC_MODE_BANK_A,
      gpio_edge_pkg::ADDR_LOGIC_MODE_BANK_B, gpio_edge_pkg::ADDR_ADVANCED_OPTIONS: wr_hit = 1'b1;
      default: wr_hit = (aw_addr_r >= gpio_edge_pkg::ADDR_TABLE_BASE) &&
                        (aw_addr_r < gpio_edge_pkg::ADDR_TABLE_BASE + 8'h18) && (aw_addr_r[1:0] == 2'b00);
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= gpio_edge_pkg::RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else
    begin
      if (axi_req.awvalid && awready_r)
      begin
        awready_r <= 1'b0;
        aw_addr_r <= axi_req.awaddr;
      end
      if (axi_req.wvalid && wready_r)
      begin
        wready_r <= 1'b0;
        w_data_r <= axi_req.wdata;
        w_strb_r <= axi_req.wstrb;
      end
      if (wr_fire)
      begin
        awready_r <= 1'b1;
        wready_r <= 1'b1;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? gpio_edge_pkg::RESP_OKAY : gpio_edge_pkg::RESP_SLVERR;
      end
      else if (bvalid_r && axi_req.bready)
        bvalid_r <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      io_value_r <= gpio_edge_pkg::IO_VALUE_RST;
      io_direction_r <= gpio_edge_pkg::IO_DIRECTION_RST;
      irq_mask_r <= gpio_edge_pkg::IRQ_MASK_RST;
      edge_sense_r <= 32'h0000_0000;
      logic_mode_bank_a_r <= gpio_edge_pkg::BYTE_RST;
      logic_mode_bank_b_r <= gpio_edge_pkg::BYTE_RST;
      advanced_options_reg_r <= gpio_edge_pkg::BYTE_RST;
      for (int i = 0; i < gpio_edge_pkg::NUM_TABLES; i++)
        truth_table_r[i] <= gpio_edge_pkg::BYTE_RST;
    end
    else if (wr_fire)
    begin
      unique case (aw_addr_r)
        gpio_edge_pkg::ADDR_IO_VALUE: io_value_r <= merge16(io_value_r, w_data_r, w_strb_r);
        gpio_edge_pkg::ADDR_IO_DIRECTION: io_direction_r <= merge16(io_direction_r, w_data_r, w_strb_r);
        gpio_edge_pkg::ADDR_IRQ_MASK: irq_mask_r <= merge16(irq_mask_r, w_data_r, w_strb_r);
        gpio_edge_pkg::ADDR_EDGE_SENSE_LOW: edge_sense_r[15:0] <= merge16(edge_sense_r[15:0], w_data_r, w_strb_r);
        gpio_edge_pkg::ADDR_EDGE_SENSE_HIGH:
          edge_sense_r[31:16] <= merge16(edge_sense_r[31:16], w_data_r, w_strb_r);
        gpio_edge_pkg::ADDR_LOGIC_MODE_BANK_A: logic_mode_bank_a_r <= wr_val_8 | (logic_mode_bank_a_r &
                                                                     {8{~w_strb_r[0]}});
        gpio_edge_pkg::ADDR_LOGIC_MODE_BANK_B: logic_mode_bank_b_r <= wr_val_8 | (logic_mode_bank_b_r &
                                                                     {8{~w_strb_r[0]}});
        gpio_edge_pkg::ADDR_ADVANCED_OPTIONS: advanced_options_reg_r <= wr_val_8 | (advanced_options_reg_r &
                                                                        {8{~w_strb_r[0]}});
        default:
        begin
          for (int i = 0; i < gpio_edge_pkg::NUM_TABLES; i++)
            if (aw_addr_r == gpio_edge_pkg::ADDR_TABLE_BASE + 8'(4 * i) && w_strb_r[0])
              truth_table_r[i] <= w_data_r[7:0];
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  assign rd_fire = axi_req.arvalid & arready_r;

  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 16'h0000;
    unique case (axi_req.araddr)
      gpio_edge_pkg::ADDR_IO_VALUE: rd_val = sync2_r;
      gpio_edge_pkg::ADDR_IO_DIRECTION: rd_val = io_direction_r;
      gpio_edge_pkg::ADDR_IRQ_MASK: rd_val = irq_mask_r;
      gpio_edge_pkg::ADDR_EDGE_SENSE_LOW: rd_val = edge_sense_r[15:0];
      gpio_edge_pkg::ADDR_EDGE_SENSE_HIGH: rd_val = edge_sense_r[31:16];
      gpio_edge_pkg::ADDR_IRQ_SOURCE: rd_val = irq_source_r;
      gpio_edge_pkg::ADDR_EVENT_STATUS: rd_val = event_status_r;
      gpio_edge_pkg::ADDR_LOGIC_MODE_BANK_A: rd_val = {8'h00, logic_mode_bank_a_r};
      gpio_edge_pkg::ADDR_LOGIC_MODE_BANK_B: rd_val = {8'h00, logic_mode_bank_b_r};
      gpio_edge_pkg::ADDR_ADVANCED_OPTIONS: rd_val = {8'h00, advanced_options_reg_r};
      default:
      begin
        rd_hit = 1'b0;
        for (int i = 0; i < gpio_edge_pkg::NUM_TABLES; i++)
          if (axi_req.araddr == gpio_edge_pkg::ADDR_TABLE_BASE + 8'(4 * i))
          begin
            rd_hit = 1'b1;
            rd_val = {8'h00, truth_table_r[i]};
          end
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= gpio_edge_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= {16'h0000, rd_val};
      rresp_r <= rd_hit ? gpio_edge_pkg::RESP_OKAY : gpio_edge_pkg::RESP_SLVERR;
    end
    else if (rvalid_r && axi_req.rready)
    begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign axi_rsp = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r, bresp: bresp_r,
                     arready: arready_r, rvalid: rvalid_r, rdata: rdata_r, rresp: rresp_r};
  assign io_out = io_out_r;
  assign io_oe_n = io_oe_n_r;
  // Open drain: only ever pulls low
  assign irq_out_low = 1'b0;
  assign irq_out_low_oe_n = irq_oe_n_r;

endmodule

// File: verif/gpio_edge_irq_sva.sv
// Assertion checker for the edge interrupt and logic-function expander
`timescale 1ns/1ps
module gpio_edge_irq_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire gpio_edge_pkg::axi_req_t axi_req,
  input wire gpio_edge_pkg::axi_rsp_t axi_rsp,
  input wire logic [15:0] io_in,
  input wire logic [15:0] io_out,
  input wire logic [15:0] io_oe_n,
  input wire logic irq_out_low,
  input wire logic irq_out_low_oe_n
);
  logic [7:0] wa_r;
  logic [15:0] wd_r;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // Last write address and data, so a clear can be recognised at its response
  always_ff @(posedge clock)
  begin
    if (axi_req.awvalid && axi_rsp.awready)
    begin
      wa_r <= axi_req.awaddr;
    end
  end
  always_ff @(posedge clock)
  begin
    if (axi_req.wvalid && axi_rsp.wready)
    begin
      wd_r <= axi_req.wdata[15:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_RST_REL: assert property ($rose(nrst) |-> irq_out_low_oe_n && io_oe_n == 16'hffff)
    else $error("pin drive active after reset");
  AST_RST_QUIET: assert property ($rose(nrst) |-> irq_out_low_oe_n [*3])
    else $error("interrupt raised straight after reset");
  AST_EDGE_CAUSE: assert property ($fell(irq_out_low_oe_n) |-> $past(io_in, 3) != $past(io_in, 4))
    else $error("interrupt without a pin change three cycles before");
  AST_PIN_DATA: assert property (irq_out_low == 1'b0)
    else $error("interrupt pin data not low");
  AST_RELEASE_CAUSE: assert property ($rose(irq_out_low_oe_n) |->
    axi_rsp.bvalid || axi_rsp.rvalid || $past(axi_rsp.rvalid))
    else $error("interrupt released without a register access");
  // Guarded against a fresh edge landing on the clear, where set wins
  AST_CLEAR: assert property ($rose(axi_rsp.bvalid) && wa_r == gpio_edge_pkg::ADDR_IRQ_SOURCE &&
    wd_r == 16'hffff && $past(io_in, 3) == $past(io_in, 4) |-> irq_out_low_oe_n)
    else $error("clear write left interrupt pending");
  AST_OE_CAUSE: assert property ($changed(io_oe_n) |-> axi_rsp.bvalid || $past(axi_rsp.bvalid))
    else $error("pin direction changed without a write");
  AST_WR_ANSWER: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready &&
    !axi_rsp.bvalid |-> ##2 axi_rsp.bvalid)
    else $error("write response late");
  AST_RD_ANSWER: assert property (axi_req.arvalid && axi_rsp.arready |-> ##[1:2] axi_rsp.rvalid)
    else $error("read response late");
  cover property ($fell(irq_out_low_oe_n));
  cover property ($rose(irq_out_low_oe_n) && axi_rsp.rvalid);
  cover property (axi_rsp.bvalid && axi_rsp.bresp == gpio_edge_pkg::RESP_SLVERR);
endmodule

// File: verif/pin_env.sv
// Pin-side partner: external sources, pin resolution and interrupt pull-up
`timescale 1ns/1ps
module pin_env (
  input wire logic [15:0] ext,
  input wire logic [15:0] io_out,
  input wire logic [15:0] io_oe_n,
  input wire logic irq_out_low,
  input wire logic irq_out_low_oe_n,
  output logic [15:0] pins,
  output logic irq_line
);
  // Device wins where it drives; elsewhere the external source sets the level
  assign pins = (ext & io_oe_n) | (io_out & ~io_oe_n);
  // Pulled up, so a released line reads high
  assign irq_line = irq_out_low_oe_n ? 1'b1 : irq_out_low;
endmodule

// File: verif/tb_top.sv
// Self-checking testbench for the edge interrupt and logic-function expander
`timescale 1ns/1ps
module tb_top;
  localparam logic [1:0] OK = gpio_edge_pkg::RESP_OKAY;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  gpio_edge_pkg::axi_req_t req = '0;
  gpio_edge_pkg::axi_rsp_t rsp;
  logic [15:0] ext = 16'h0000;
  logic [15:0] pins;
  logic [15:0] io_out;
  logic [15:0] io_oe_n;
  logic irq_low;
  logic irq_oe_n;
  logic irq_line;
  logic [31:0] d;
  int err_total = 0;
  int checked = 0;
  always #25 clock = ~clock;
  gpio_edge_irq uut (.clock(clock), .nrst(nrst), .axi_req(req), .axi_rsp(rsp), .io_in(pins), .io_out(io_out),
    .io_oe_n(io_oe_n), .irq_out_low(irq_low), .irq_out_low_oe_n(irq_oe_n));
  pin_env env (.ext(ext), .io_out(io_out), .io_oe_n(io_oe_n), .irq_out_low(irq_low),
    .irq_out_low_oe_n(irq_oe_n), .pins(pins), .irq_line(irq_line));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] resp);
    logic ap;
    logic wp;
    ap = 1'b1;
    wp = 1'b1;
    @(posedge clock);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    // Address and data may be taken on different edges
    while (ap || wp)
    begin
      @(posedge clock);
      if (ap && rsp.awready === 1'b1)
      begin
        req.awvalid <= 1'b0;
        ap = 1'b0;
      end
      if (wp && rsp.wready === 1'b1)
      begin
        req.wvalid <= 1'b0;
        wp = 1'b0;
      end
    end
    @(posedge clock iff rsp.bvalid === 1'b1);
    req.bready <= 1'b0;
    check({30'h0, rsp.bresp}, {30'h0, resp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] resp);
    @(posedge clock);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    @(posedge clock iff rsp.arready === 1'b1);
    req.arvalid <= 1'b0;
    @(posedge clock iff rsp.rvalid === 1'b1);
    d = rsp.rdata;
    req.rready <= 1'b0;
    check({30'h0, rsp.rresp}, {30'h0, resp});
  endtask
  // Edges need three cycles to reach the flags; five leaves margin
  task automatic drive(input logic [15:0] v);
    @(posedge clock);
    ext <= v;
    repeat (5) @(posedge clock);
  endtask
  task automatic do_reset();
    @(posedge clock);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_state();
    @(posedge clock);
    check({31'h0, irq_line}, 32'h1);
    check({16'h0, io_oe_n}, 32'h0000ffff);
    rd(gpio_edge_pkg::ADDR_IRQ_MASK, OK);
    check(d, 32'h0000ffff);
    rd(gpio_edge_pkg::ADDR_IRQ_SOURCE, OK);
    check(d, 32'h0);
    rd(gpio_edge_pkg::ADDR_EVENT_STATUS, OK);
    check(d, 32'h0);
  endtask
  // Every sense code on I/O 1, each against a rising then a falling edge
  task automatic t_edges();
    for (int s = 0; s < 4; s++)
    begin
      wr(gpio_edge_pkg::ADDR_IRQ_MASK, 32'h0000fffd, OK);
      wr(gpio_edge_pkg::ADDR_EDGE_SENSE_LOW, 32'(s) << 2, OK);
      for (int e = 0; e < 2; e++)
      begin
        drive(e == 0 ? 16'h0002 : 16'h0000);
        rd(gpio_edge_pkg::ADDR_IRQ_SOURCE, OK);
        check(d, {30'h0, s[e], 1'b0});
        check({31'h0, irq_line}, {31'h0, ~s[e]});
        wr(gpio_edge_pkg::ADDR_IRQ_SOURCE, 32'h0000ffff, OK);
        rd(gpio_edge_pkg::ADDR_EVENT_STATUS, OK);
        check(d, 32'h0);
        check({31'h0, irq_line}, 32'h1);
      end
    end
  endtask
  task automatic t_mask();
    wr(gpio_edge_pkg::ADDR_IRQ_MASK, 32'h0000ffff, OK);
    wr(gpio_edge_pkg::ADDR_EDGE_SENSE_LOW, 32'h00000030, OK);
    drive(16'h0004);
    rd(gpio_edge_pkg::ADDR_IRQ_SOURCE, OK);
    check(d, 32'h0);
    rd(gpio_edge_pkg::ADDR_EVENT_STATUS, OK);
    check(d, 32'h00000004);
    check({31'h0, irq_line}, 32'h1);
    wr(gpio_edge_pkg::ADDR_EVENT_STATUS, 32'h0000ffff, OK);
  endtask
  task automatic t_autoclear();
    wr(gpio_edge_pkg::ADDR_ADVANCED_OPTIONS, 32'h00000001, OK);
    wr(gpio_edge_pkg::ADDR_IRQ_MASK, 32'h0000fffb, OK);
    drive(16'h0000);
    check({31'h0, irq_line}, 32'h0);
    rd(gpio_edge_pkg::ADDR_IO_VALUE, OK);
    check(d, 32'h0);
    @(posedge clock);
    check({31'h0, irq_line}, 32'h1);
    rd(gpio_edge_pkg::ADDR_IRQ_SOURCE, OK);
    check(d, 32'h0);
    wr(gpio_edge_pkg::ADDR_ADVANCED_OPTIONS, 32'h0, OK);
  endtask
  // Reset with an interrupt pending must release the line
  task automatic t_midreset();
    drive(16'h0004);
    check({31'h0, irq_line}, 32'h0);
    do_reset();
    t_reset_state();
  endtask
  // AND of I/O 1:0 on I/O 2, three-input AND on I/O 10:8 driving I/O 11
  task automatic t_logic();
    wr(gpio_edge_pkg::ADDR_LOGIC_MODE_BANK_A, 32'h00000001, OK);
    wr(gpio_edge_pkg::ADDR_TABLE_BASE, 32'h00000008, OK);
    wr(gpio_edge_pkg::ADDR_LOGIC_MODE_BANK_B, 32'h00000002, OK);
    wr(gpio_edge_pkg::ADDR_TABLE_BASE + 8'h0c, 32'h00000080, OK);
    for (int v = 0; v < 8; v++)
    begin
      drive({5'h0, v[2:0], 6'h0, v[1:0]});
      check({16'h0, io_oe_n}, 32'h0000f7fb);
      check({31'h0, pins[2]}, {31'h0, v[1:0] == 2'b11});
      check({31'h0, pins[11]}, {31'h0, v == 7});
    end
  endtask
  // Parity and majority three-to-two on bank A, upper XOR on bank B, I/O 5 as plain output
  task automatic t_logic_wide();
    wr(gpio_edge_pkg::ADDR_IO_VALUE, 32'h0000ffdf, OK);
    wr(gpio_edge_pkg::ADDR_IO_DIRECTION, 32'h0000ffdf, OK);
    wr(gpio_edge_pkg::ADDR_LOGIC_MODE_BANK_A, 32'h00000013, OK);
    wr(gpio_edge_pkg::ADDR_TABLE_BASE, 32'h00000096, OK);
    wr(gpio_edge_pkg::ADDR_TABLE_BASE + 8'h04, 32'h000000e8, OK);
    wr(gpio_edge_pkg::ADDR_LOGIC_MODE_BANK_B, 32'h00000010, OK);
    wr(gpio_edge_pkg::ADDR_TABLE_BASE + 8'h14, 32'h00000006, OK);
    rd(gpio_edge_pkg::ADDR_TABLE_BASE + 8'h04, OK);
    check(d, 32'h000000e8);
    for (int v = 0; v < 8; v++)
    begin
      drive({2'h0, v[1:0], 9'h0, v[2:0]});
      check({16'h0, io_oe_n}, 32'h0000bfc7);
      check({31'h0, pins[3]}, {31'h0, ^v[2:0]});
      check({31'h0, pins[4]}, {31'h0, (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2])});
      check({31'h0, pins[14]}, {31'h0, v[1] ^ v[0]});
      check({30'h0, pins[6:5]}, 32'h0);
    end
  endtask
  task automatic t_unmapped();
    wr(8'h40, 32'h0000ffff, gpio_edge_pkg::RESP_SLVERR);
    rd(8'h40, gpio_edge_pkg::RESP_SLVERR);
    check(d, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial
  begin
    do_reset();
    t_reset_state();
    t_edges();
    t_mask();
    t_autoclear();
    t_midreset();
    t_logic();
    t_logic_wide();
    t_unmapped();
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    err_total++;
    summarize();
  end
endmodule
bind gpio_edge_irq gpio_edge_irq_chk chk (.clock(clock), .nrst(nrst), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .irq_out_low(irq_out_low),
  .irq_out_low_oe_n(irq_out_low_oe_n));
